// ### hw/bss_consts.svh
// Constants for the burner safety sequencer and annunciator
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH

`define BSS_CLK_HZ 125000000
`define BSS_TICK_S 1
`define BSS_HOLD_S 16'h0001
`define BSS_FO_MAX 4'hF
`define BSS_POST_MAX_MIN 5
`define BSS_POST_MAX_S (16'(`BSS_POST_MAX_MIN * 60))
`define BSS_SEC_MAX 16'hFFFF

`define BSS_A_CTRL 12'h000
`define BSS_A_TIMES 12'h004
`define BSS_A_SEQT 12'h008
`define BSS_A_STAT 12'h00C
`define BSS_A_CONT 12'h010
`define BSS_A_RANK0 12'h014
`define BSS_A_RANK1 12'h018
`define BSS_A_MSG 12'h01C
`define BSS_A_CFG 12'h040
`define BSS_CFG_SPAN 12'h02C
`define BSS_A_NAME 12'h100
`define BSS_NAME_SPAN 12'h0DC

`define BSS_C_FLREC 0
`define BSS_C_FANREC 1
`define BSS_C_PHOLD 2
`define BSS_C_PTYPE 4:3
`define BSS_C_ISRC 6:5
`define BSS_C_AIR 7
`define BSS_C_HFP 8
`define BSS_C_LFP 9
`define BSS_C_LKCLR 31

`define BSS_CTRL_RST 32'h0000_0008
`define BSS_TIMES_RST 32'h000F_000A
`define BSS_SEQT_RST 32'h0004_000A

`define BSS_N_PTS 11
`define BSS_N_LNAME 55
`define BSS_NAME_WORDS 5
`define BSS_P_AIR 0
`define BSS_P_HFP 6
`define BSS_P_LFP 7
`define BSS_P_ILK 8
`define BSS_P_LCI 9
`define BSS_P_PII 10
`define BSS_POS_LAST 4'hF
`define BSS_RANK_NONE 4'hF

`define BSS_SN_AIR 24'h415352
`define BSS_SN_HFP 24'h484650
`define BSS_SN_LFP 24'h4C4650

`endif

// ### hw/bss_pkg.sv
// Types for the burner safety sequencer and annunciator
package bss_pkg;
	typedef enum logic [2:0] {
		BSS_ST_STANDBY,
		BSS_ST_PREPURGE,
		BSS_ST_IGNITION,
		BSS_ST_RUN,
		BSS_ST_POSTPURGE,
		BSS_ST_LOCKOUT
	} bss_state_t;
	typedef enum logic [1:0] {
		BSS_PILOT_DIRECT = 2'h0,
		BSS_PILOT_INTERRUPTED = 2'h1,
		BSS_PILOT_INTERMITTENT = 2'h2
	} bss_pilot_t;
	typedef enum logic [1:0] {
		BSS_IGN_INTERNAL = 2'h0,
		BSS_IGN_EXTERNAL = 2'h1,
		BSS_IGN_HOT_SURFACE = 2'h2
	} bss_ign_t;
	typedef enum logic [2:0] {
		BSS_LOC_LOAD = 3'h0,
		BSS_LOC_INTERLOCK = 3'h1,
		BSS_LOC_PREIGN = 3'h2,
		BSS_LOC_UNUSED = 3'h3,
		BSS_LOC_OTHER = 3'h4
	} bss_loc_t;
endpackage

// ### hw/bss_tick.sv
// One-second timebase for all sequence timers
`timescale 1ns/100ps
module bss_tick #(
	parameter int unsigned DIV = 125000000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Timebase
	output logic tick_o
);
	logic [31:0] cnt;
	wire wrap = (cnt == 32'(DIV - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			cnt <= wrap ? 32'h0000_0000 : cnt + 32'h0000_0001;
			tick_o <= wrap;
		end
	end
endmodule

// ### hw/bss_annun.sv
// Annunciator point configuration, names, sorting and first-out
`timescale 1ns/100ps
`include "bss_consts.svh"
module bss_annun (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register access
	input wire logic wr_cfg_i,
	input wire logic wr_name_i,
	input wire logic [5:0] idx_i,
	input wire logic [31:0] wdat_i,
	output logic [31:0] cfg_rd_o,
	output logic [31:0] name_rd_o,
	// Contacts and dedications
	input wire logic [10:0] contacts_i,
	input wire logic [2:0] ded_i,
	// Sorted view
	output logic [43:0] rank_o,
	output logic [3:0] first_idx_o,
	output logic [23:0] first_name_o
);
	logic [10:0][2:0] loc;
	logic [10:0][23:0] sname;
	logic [31:0] lname [0:`BSS_N_LNAME-1];
	logic [10:0][23:0] disp;
	logic [10:0][2:0] loc_eff;
	logic [10:0][5:0] key;
	logic [10:0] ded;
	logic [10:0] used;
	logic [10:0][3:0] rank;
	wire cfg_ok = (idx_i < 6'(`BSS_N_PTS));
	wire name_ok = (idx_i < 6'(`BSS_N_LNAME));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `BSS_N_PTS; i++) begin
				loc[i] <= bss_pkg::BSS_LOC_UNUSED;
				sname[i] <= 24'h000000;
			end
		end else if (ce_i && wr_cfg_i && cfg_ok) begin
			loc[idx_i[3:0]] <= wdat_i[2:0];
			sname[idx_i[3:0]] <= wdat_i[31:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && wr_name_i && name_ok) begin
			lname[idx_i] <= wdat_i;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `BSS_N_PTS; gi++) begin : g_pt
			localparam bit FIXED = (gi >= `BSS_P_ILK);
			localparam logic [2:0] FLOC = (gi == `BSS_P_LCI) ?
				bss_pkg::BSS_LOC_LOAD : (gi == `BSS_P_PII) ?
				bss_pkg::BSS_LOC_PREIGN : bss_pkg::BSS_LOC_INTERLOCK;
			localparam logic [23:0] AUTO = (gi == `BSS_P_AIR) ?
				`BSS_SN_AIR : (gi == `BSS_P_HFP) ?
				`BSS_SN_HFP : `BSS_SN_LFP;
			assign ded[gi] = (gi == `BSS_P_AIR && ded_i[0]) ||
				(gi == `BSS_P_HFP && ded_i[1]) ||
				(gi == `BSS_P_LFP && ded_i[2]);
			assign disp[gi] = ded[gi] ? AUTO : sname[gi];
			assign loc_eff[gi] = FIXED ? FLOC : loc[gi];
			assign used[gi] = (loc_eff[gi] != bss_pkg::BSS_LOC_UNUSED);
			assign key[gi] = {(loc_eff[gi] <= bss_pkg::BSS_LOC_PREIGN) ?
				loc_eff[gi][1:0] : 2'h3,
				FIXED ? `BSS_POS_LAST : 4'(gi)};
			// Local count keeps each process the only writer
			logic [3:0] pos;
			always_comb begin
				pos = 4'h0;
				for (int j = 0; j < `BSS_N_PTS; j++) begin
					if (key[j] < key[gi]) begin
						pos = pos + 4'h1;
					end
				end
			end
			assign rank[gi] = pos;
			assign rank_o[gi*4 +: 4] = rank[gi];
		end
	endgenerate

	// first open point in sort order
	always_comb begin
		logic [3:0] best;
		best = `BSS_RANK_NONE;
		first_idx_o = `BSS_RANK_NONE;
		for (int i = 0; i < `BSS_N_PTS; i++) begin
			if (!contacts_i[i] && used[i] && rank[i] < best) begin
				best = rank[i];
				first_idx_o = 4'(i);
			end
		end
	end
	assign first_name_o = (first_idx_o < 4'(`BSS_N_PTS)) ?
		disp[first_idx_o] : 24'h000000;

	assign cfg_rd_o = cfg_ok ? {disp[idx_i[3:0]], ded[idx_i[3:0]], 4'h0,
		loc_eff[idx_i[3:0]]} : 32'h0000_0000;
	assign name_rd_o = name_ok ? lname[idx_i] : 32'h0000_0000;
endmodule

// ### hw/bss_top.sv
// Burner safety sequencer with annunciator behind a Wishbone slave
// Behaviour
// - Run flame failure locks out or recycles
// - Run fan failure recycles or locks out
// - Pilot test hold ignored for direct ignition
// - Hold sequence one second into ignition
// - Flame-out timer cleared, counts up/down
// - Flame-out timer at fifteen causes lockout
// - Internal, external or hot surface ignition
// - Hold light-off rate during stabilization
// - Zero stabilization releases modulation at once
// - Postpurge up to five minutes, zero skips
// - Eleven monitored annunciator contact points
// - Long and short name per input
// - Short name tags lockout and hold
// - Each input assigned one location
// - Fixed terminals can be renamed
// - First input becomes air switch
// - Seventh input becomes high fire proof
// - Eighth input becomes low fire proof
// - Sort by category then index
// - Dedicated inputs show automatic names
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "bss_consts.svh"
module bss_top #(
	parameter int unsigned TICK_DIV = `BSS_CLK_HZ * `BSS_TICK_S
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Field inputs
	input wire logic demand_i,
	input wire logic flame_i,
	input wire logic fan_ok_i,
	input wire logic [7:0] annunciator_contact_inputs_i,
	input wire logic interlock_string_input_i,
	input wire logic load_limit_control_input_i,
	input wire logic preignition_interlock_input_i,
	// Burner outputs
	output logic blower_o,
	output logic pilot_valve_o,
	output logic main_valve_o,
	output logic spark_o,
	output logic ext_ign_o,
	output logic hot_surface_o,
	output logic rate_release_o,
	output logic lockout_o,
	output logic pilot_hold_o
);
	bss_pkg::bss_state_t st;
	bss_pkg::bss_state_t next_state;
	logic [13:0] sync1;
	logic [13:0] sync2;
	logic [31:0] ctrl;
	logic [31:0] times;
	logic [31:0] seqt;
	logic [15:0] sec;
	logic [3:0] fo;
	logic [27:0] msg;
	logic tick;
	logic [31:0] cfg_rd;
	logic [31:0] name_rd;
	logic [43:0] rank;
	logic [3:0] first_idx;
	logic [23:0] first_name;

	// Field pins are asynchronous to clk_i
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 14'h0000;
			sync2 <= 14'h0000;
		end else if (ce_i) begin
			sync1 <= {demand_i, flame_i, fan_ok_i,
				preignition_interlock_input_i,
				load_limit_control_input_i,
				interlock_string_input_i,
				annunciator_contact_inputs_i};
			sync2 <= sync1;
		end
	end

	wire dem_s = sync2[13];
	wire flame_s = sync2[12];
	wire fan_s = sync2[11];
	wire [10:0] contacts = sync2[10:0];
	wire ilk_s = contacts[`BSS_P_ILK];

	bss_tick #(
		.DIV(TICK_DIV)
	) i_bss_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(tick)
	);

	// Configuration decode
	wire [1:0] ptype = ctrl[`BSS_C_PTYPE];
	wire [1:0] isrc = ctrl[`BSS_C_ISRC];
	wire flrec = ctrl[`BSS_C_FLREC];
	wire fanrec = ctrl[`BSS_C_FANREC];
	wire direct_burner_ignition = (ptype == bss_pkg::BSS_PILOT_DIRECT);
	wire hold_eff = ctrl[`BSS_C_PHOLD] && !direct_burner_ignition;
	wire [15:0] stab = times[15:0];
	wire [15:0] post_cfg = times[31:16];
	wire [15:0] post_eff = (post_cfg > `BSS_POST_MAX_S) ?
		`BSS_POST_MAX_S : post_cfg;
	wire [15:0] prep = seqt[15:0];
	wire [15:0] ign_t = {8'h00, seqt[23:16]};
	wire in_ign = (st == bss_pkg::BSS_ST_IGNITION);
	wire in_run = (st == bss_pkg::BSS_ST_RUN);
	wire held = in_ign && hold_eff && (sec == `BSS_HOLD_S);
	wire early = hold_eff && (sec <= `BSS_HOLD_S);
	wire fo_full = (fo == `BSS_FO_MAX);

	// Register bus decode
	wire req = wb_cyc_i && wb_stb_i;
	wire [11:0] adr = {wb_adr_i[11:2], 2'h0};
	wire [11:0] cfg_off = adr - `BSS_A_CFG;
	wire [11:0] name_off = adr - `BSS_A_NAME;
	wire hit_ctrl = (adr == `BSS_A_CTRL);
	wire hit_times = (adr == `BSS_A_TIMES);
	wire hit_seqt = (adr == `BSS_A_SEQT);
	wire hit_cfg = (adr >= `BSS_A_CFG) && (cfg_off < `BSS_CFG_SPAN);
	wire hit_name = (adr >= `BSS_A_NAME) && (name_off < `BSS_NAME_SPAN);
	wire [5:0] an_idx = hit_cfg ? cfg_off[7:2] : name_off[7:2];
	wire [31:0] rd_mux =
		hit_ctrl ? ctrl :
		hit_times ? times :
		hit_seqt ? seqt :
		(adr == `BSS_A_STAT) ? {sec, 4'h0, fo, 5'h00, st} :
		(adr == `BSS_A_CONT) ? {21'h000000, contacts} :
		(adr == `BSS_A_RANK0) ? rank[31:0] :
		(adr == `BSS_A_RANK1) ? {20'h00000, rank[43:32]} :
		(adr == `BSS_A_MSG) ? {4'h0, msg} :
		hit_cfg ? cfg_rd :
		hit_name ? name_rd : 32'h0000_0000;
	wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] merged = (wb_dat_i & bmask) | (rd_mux & ~bmask);
	// Write lands on the edge where the master sees ack
	wire wr_fire = req && wb_we_i && wb_ack_o;
	wire lk_clr = wr_fire && hit_ctrl && merged[`BSS_C_LKCLR];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= (req && !wb_ack_o) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `BSS_CTRL_RST;
			times <= `BSS_TIMES_RST;
			seqt <= `BSS_SEQT_RST;
		end else if (ce_i && wr_fire) begin
			// Clear bit is a strobe, never stored
			if (hit_ctrl) begin
				ctrl <= {1'b0, merged[30:0]};
			end
			if (hit_times) begin
				times <= merged;
			end
			if (hit_seqt) begin
				seqt <= merged;
			end
		end
	end

	bss_annun i_bss_annun (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wr_cfg_i(wr_fire && hit_cfg),
		.wr_name_i(wr_fire && hit_name),
		.idx_i(an_idx),
		.wdat_i(merged),
		.cfg_rd_o(cfg_rd),
		.name_rd_o(name_rd),
		.contacts_i(contacts),
		.ded_i({ctrl[`BSS_C_LFP], ctrl[`BSS_C_HFP], ctrl[`BSS_C_AIR]}),
		.rank_o(rank),
		.first_idx_o(first_idx),
		.first_name_o(first_name)
	);

	// Sequencer
	always_comb begin
		next_state = st;
		unique case (st)
			bss_pkg::BSS_ST_STANDBY: begin
				if (dem_s && ilk_s) begin
					next_state = bss_pkg::BSS_ST_PREPURGE;
				end
			end
			bss_pkg::BSS_ST_PREPURGE: begin
				if (sec >= prep) begin
					next_state = bss_pkg::BSS_ST_IGNITION;
				end
			end
			bss_pkg::BSS_ST_IGNITION: begin
				if (hold_eff && fo_full) begin
					next_state = bss_pkg::BSS_ST_LOCKOUT;
				end else if (!early && sec >= ign_t) begin
					next_state = flame_s ? bss_pkg::BSS_ST_RUN :
						bss_pkg::BSS_ST_LOCKOUT;
				end
			end
			bss_pkg::BSS_ST_RUN: begin
				if (!flame_s) begin
					next_state = flrec ? bss_pkg::BSS_ST_PREPURGE :
						bss_pkg::BSS_ST_LOCKOUT;
				end else if (!fan_s) begin
					next_state = fanrec ? bss_pkg::BSS_ST_PREPURGE :
						bss_pkg::BSS_ST_LOCKOUT;
				end else if (!dem_s) begin
					next_state = (post_eff == 16'h0000) ?
						bss_pkg::BSS_ST_STANDBY :
						bss_pkg::BSS_ST_POSTPURGE;
				end
			end
			bss_pkg::BSS_ST_POSTPURGE: begin
				if (sec >= post_eff) begin
					next_state = bss_pkg::BSS_ST_STANDBY;
				end
			end
			bss_pkg::BSS_ST_LOCKOUT: begin
				if (lk_clr) begin
					next_state = bss_pkg::BSS_ST_STANDBY;
				end
			end
		endcase
	end

	wire leave = (next_state != st);
	wire enter_ign = leave && (next_state == bss_pkg::BSS_ST_IGNITION);
	wire n_ign = (next_state == bss_pkg::BSS_ST_IGNITION);
	wire n_run = (next_state == bss_pkg::BSS_ST_RUN);
	wire n_main = n_run || (n_ign && direct_burner_ignition);
	wire n_pilot = (n_ign && !direct_burner_ignition) ||
		(n_run && ptype == bss_pkg::BSS_PILOT_INTERMITTENT);
	wire n_release = n_run && (stab == 16'h0000 || (in_run && sec >= stab));
	wire msg_ev = (leave && next_state == bss_pkg::BSS_ST_LOCKOUT) ||
		(held && !pilot_hold_o);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= bss_pkg::BSS_ST_STANDBY;
			sec <= 16'h0000;
		end else if (ce_i) begin
			st <= next_state;
			if (leave) begin
				sec <= 16'h0000;
			end else if (tick && !held && sec != `BSS_SEC_MAX) begin
				sec <= sec + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fo <= 4'h0;
		end else if (ce_i) begin
			if (enter_ign) begin
				fo <= 4'h0;
			end else if (in_ign && hold_eff && tick) begin
				if (flame_s && fo != 4'h0) begin
					fo <= fo - 4'h1;
				end else if (!flame_s && !fo_full) begin
					fo <= fo + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			msg <= 28'h0000000;
		end else if (ce_i && msg_ev) begin
			msg <= {first_idx, first_name};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blower_o <= 1'b0;
			pilot_valve_o <= 1'b0;
			main_valve_o <= 1'b0;
			spark_o <= 1'b0;
			ext_ign_o <= 1'b0;
			hot_surface_o <= 1'b0;
			rate_release_o <= 1'b0;
			lockout_o <= 1'b0;
			pilot_hold_o <= 1'b0;
		end else if (ce_i) begin
			blower_o <= (next_state != bss_pkg::BSS_ST_STANDBY) &&
				(next_state != bss_pkg::BSS_ST_LOCKOUT);
			pilot_valve_o <= n_pilot;
			main_valve_o <= n_main;
			spark_o <= n_ign && isrc == bss_pkg::BSS_IGN_INTERNAL;
			// External source needs the string and a closed main valve
			ext_ign_o <= n_ign && isrc == bss_pkg::BSS_IGN_EXTERNAL &&
				ilk_s && !n_main;
			hot_surface_o <= n_ign && isrc == bss_pkg::BSS_IGN_HOT_SURFACE;
			rate_release_o <= n_release;
			lockout_o <= (next_state == bss_pkg::BSS_ST_LOCKOUT);
			pilot_hold_o <= held;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_run_flame;
		(ce_i && in_run && !flame_s) |=> (st == ($past(flrec) ?
			bss_pkg::BSS_ST_PREPURGE : bss_pkg::BSS_ST_LOCKOUT));
	endproperty
	a_run_flame: assert property (p_run_flame)
		else $error("run flame failure response wrong");

	property p_run_fan;
		(ce_i && in_run && flame_s && !fan_s) |=> (st == ($past(fanrec) ?
			bss_pkg::BSS_ST_PREPURGE : bss_pkg::BSS_ST_LOCKOUT));
	endproperty
	a_run_fan: assert property (p_run_fan)
		else $error("fan failure response wrong");

	property p_hold;
		(ce_i && held && !fo_full) |=> (in_ign && sec == `BSS_HOLD_S);
	endproperty
	a_hold: assert property (p_hold)
		else $error("pilot hold did not keep ignition");

	sequence s_enter_ign;
		!in_ign ##1 in_ign;
	endsequence
	property p_fo_clear;
		s_enter_ign |-> (fo == 4'h0);
	endproperty
	a_fo_clear: assert property (p_fo_clear)
		else $error("flame-out timer not cleared on entry");

	property p_fo_lock;
		(ce_i && in_ign && hold_eff && fo_full) |=>
			(st == bss_pkg::BSS_ST_LOCKOUT);
	endproperty
	a_fo_lock: assert property (p_fo_lock)
		else $error("flame-out limit did not lock out");

	property p_ext_ilk;
		ext_ign_o |-> (!main_valve_o && !spark_o && !hot_surface_o);
	endproperty
	a_ext_ilk: assert property (p_ext_ilk)
		else $error("external ignition with main valve");

	property p_stab;
		(in_run && stab != 16'h0000 && sec < stab) |-> !rate_release_o;
	endproperty
	a_stab: assert property (p_stab)
		else $error("rate released during stabilization");

	property p_stab_zero;
		(ce_i && !in_run && n_run && stab == 16'h0000) |=> rate_release_o;
	endproperty
	a_stab_zero: assert property (p_stab_zero)
		else $error("zero stabilization did not release");

	property p_post_skip;
		(ce_i && in_run && flame_s && fan_s && !dem_s &&
			post_eff == 16'h0000) |=> (st == bss_pkg::BSS_ST_STANDBY);
	endproperty
	a_post_skip: assert property (p_post_skip)
		else $error("zero postpurge not skipped");
endmodule

// ### dv/bss_field_model.sv
// Field side model: flame sensor and fan speed proof
`timescale 1ns/100ps
module bss_field_model (
	// Valve state from the sequencer
	input wire logic pilot_valve_i,
	input wire logic main_valve_i,
	// Bench controls
	input wire logic flame_en_i,
	input wire logic fan_en_i,
	// Sensed signals
	output logic flame_o,
	output logic fan_ok_o
);
	// No fuel, no flame; a lingering flame would mask valve faults
	assign flame_o = flame_en_i & (pilot_valve_i | main_valve_i);
	assign fan_ok_o = fan_en_i;
endmodule

// ### dv/tb_bss_top.sv
// Self-checking bench for the burner sequencer and annunciator
`timescale 1ns/100ps
`include "bss_consts.svh"
module tb_bss_top;
	localparam int T = 10;
	localparam logic [2:0] S_SBY = bss_pkg::BSS_ST_STANDBY;
	localparam logic [2:0] S_PRE = bss_pkg::BSS_ST_PREPURGE;
	localparam logic [2:0] S_IGN = bss_pkg::BSS_ST_IGNITION;
	localparam logic [2:0] S_RUN = bss_pkg::BSS_ST_RUN;
	localparam logic [2:0] S_POST = bss_pkg::BSS_ST_POSTPURGE;
	localparam logic [2:0] S_LOCK = bss_pkg::BSS_ST_LOCKOUT;
	logic clk = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [31:0] wb_dat = 32'h0;
	logic demand = 1'b0;
	logic ce = 1'b1;
	logic flame_en = 1'b1;
	logic fan_en = 1'b1;
	logic [7:0] contacts = 8'hFF;
	logic ilk_in = 1'b1;
	logic load_in = 1'b1;
	logic preign_in = 1'b1;
	logic flame;
	logic fan_ok;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic blower, pilot_v, main_v, spark, ext_ign, hot_s;
	logic release_o, lockout, hold;
	logic [31:0] r;
	int error_cnt = 0;
	int n_compared = 0;

	always #4 clk = ~clk;

	bss_field_model i_bss_field_model (.pilot_valve_i(pilot_v),
		.main_valve_i(main_v), .flame_en_i(flame_en), .fan_en_i(fan_en),
		.flame_o(flame), .fan_ok_o(fan_ok));

	bss_top #(.TICK_DIV(T)) i_bss_top (.clk_i(clk), .rst_i(rst_i),
		.ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .demand_i(demand),
		.flame_i(flame), .fan_ok_i(fan_ok),
		.annunciator_contact_inputs_i(contacts),
		.interlock_string_input_i(ilk_in),
		.load_limit_control_input_i(load_in),
		.preignition_interlock_input_i(preign_in), .blower_o(blower),
		.pilot_valve_o(pilot_v), .main_valve_o(main_v), .spark_o(spark),
		.ext_ign_o(ext_ign), .hot_surface_o(hot_s),
		.rate_release_o(release_o), .lockout_o(lockout),
		.pilot_hold_o(hold));

	task wrap_up;
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task secs(input int s);
		repeat (s * T) @(posedge clk);
	endtask

	// Classic single cycle; request held until ack is sampled
	task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		begin
			wb_cyc <= 1'b1;
			wb_stb <= 1'b1;
			wb_we <= we;
			wb_adr <= a;
			wb_dat <= d;
			@(posedge clk);
			// No local limit; only the watchdog ends a hung wait
			while (wb_ack_o !== 1'b1) begin
				@(posedge clk);
			end
			r = wb_dat_o;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
			wb_we <= 1'b0;
			@(posedge clk);
		end
	endtask

	task wait_st(input logic [2:0] st, input int lim);
		int k;
		begin
			k = 0;
			r = '1;
			while (r[2:0] !== st && k < lim) begin
				wb(1'b0, `BSS_A_STAT, 32'h0);
				k++;
			end
			chk({29'h0, r[2:0]}, {29'h0, st});
		end
	endtask

	task t_regs;
		wb(1'b0, `BSS_A_CTRL, 32'h0);
		chk(r, `BSS_CTRL_RST);
		wb(1'b0, `BSS_A_STAT, 32'h0);
		chk(r, 32'h0);
		wb(1'b0, 12'h800, 32'h0);
		chk(r, 32'h0);
		// Ceiling acts on use; the field reads back as written
		wb(1'b1, `BSS_A_TIMES, 32'hFFFF_0000);
		wb(1'b0, `BSS_A_TIMES, 32'h0);
		chk(r, 32'hFFFF_0000);
		wb(1'b1, `BSS_A_SEQT, 32'h0002_0001);
	endtask

	task t_ann;
		logic [2:0] fix [3];
		logic [7:0] pt [3];
		logic [23:0] nm [3];
		begin
			fix = '{3'h1, 3'h0, 3'h2};
			pt = '{8'h00, 8'h18, 8'h1C};
			nm = '{`BSS_SN_AIR, `BSS_SN_HFP, `BSS_SN_LFP};
			contacts <= 8'hA5;
			preign_in <= 1'b0;
			repeat (4) @(posedge clk);
			wb(1'b0, `BSS_A_CONT, 32'h0);
			chk(r, 32'h0000_03A5);
			contacts <= 8'hFF;
			preign_in <= 1'b1;
			for (int i = 0; i < 3; i++) begin
				wb(1'b0, `BSS_A_CFG + 12'h020 + 12'(4 * i), 32'h0);
				chk({29'h0, r[2:0]}, {29'h0, fix[i]});
			end
			wb(1'b1, `BSS_A_CFG + 12'h020, 32'h5354_5200);
			wb(1'b0, `BSS_A_CFG + 12'h020, 32'h0);
			chk({8'h0, r[31:8]}, 32'h0053_5452);
			wb(1'b1, `BSS_A_CFG + 12'h004, 32'h4142_4304);
			wb(1'b0, `BSS_A_CFG + 12'h004, 32'h0);
			chk(r, 32'h4142_4304);
			wb(1'b1, `BSS_A_NAME + 12'h014, 32'h4C4F_4E47);
			wb(1'b0, `BSS_A_NAME + 12'h014, 32'h0);
			chk(r, 32'h4C4F_4E47);
			wb(1'b1, `BSS_A_CFG, 32'h5858_5803);
			wb(1'b1, `BSS_A_CTRL, 32'h0000_0388);
			for (int i = 0; i < 3; i++) begin
				wb(1'b0, `BSS_A_CFG + 12'(pt[i]), 32'h0);
				chk({7'h0, r[31:7]}, {7'h0, nm[i], 1'b1});
			end
			wb(1'b1, `BSS_A_CTRL, 32'h0000_0008);
			wb(1'b0, `BSS_A_CFG, 32'h0);
			chk(r, 32'h5858_5803);
			wb(1'b1, `BSS_A_CFG + 12'h008, 32'h4F50_4504);
			// Fixed terminals last in their category, unused with other
			wb(1'b0, `BSS_A_RANK0, 32'h0);
			chk(r, 32'hA987_6543);
			wb(1'b0, `BSS_A_RANK1, 32'h0);
			chk(r, 32'h0000_0201);
		end
	endtask

	task t_stab;
		wb(1'b1, `BSS_A_TIMES, 32'h0003_0002);
		// Enable low: demand must not start a sequence
		ce <= 1'b0;
		demand <= 1'b1;
		repeat (40) @(posedge clk);
		chk({31'h0, blower}, 32'h0);
		ce <= 1'b1;
		wait_st(S_RUN, 60);
		chk({31'h0, release_o}, 32'h0);
		secs(1);
		chk({31'h0, release_o}, 32'h0);
		secs(2);
		chk({31'h0, release_o}, 32'h1);
		demand <= 1'b0;
		wait_st(S_POST, 6);
		secs(1);
		wb(1'b0, `BSS_A_STAT, 32'h0);
		chk({29'h0, r[2:0]}, {29'h0, S_POST});
		wait_st(S_SBY, 15);
		wb(1'b1, `BSS_A_TIMES, 32'h0000_0000);
		demand <= 1'b1;
		wait_st(S_RUN, 60);
		repeat (2) @(posedge clk);
		chk({31'h0, release_o}, 32'h1);
		demand <= 1'b0;
		repeat (6) @(posedge clk);
		wb(1'b0, `BSS_A_STAT, 32'h0);
		chk({29'h0, r[2:0]}, {29'h0, S_SBY});
	endtask

	task t_faults;
		wb(1'b1, `BSS_A_CTRL, 32'h0000_0009);
		demand <= 1'b1;
		wait_st(S_RUN, 60);
		flame_en <= 1'b0;
		wait_st(S_PRE, 6);
		flame_en <= 1'b1;
		wait_st(S_RUN, 60);
		wb(1'b1, `BSS_A_CTRL, 32'h0000_000A);
		fan_en <= 1'b0;
		wait_st(S_PRE, 6);
		fan_en <= 1'b1;
		wait_st(S_RUN, 60);
		wb(1'b1, `BSS_A_CTRL, 32'h0000_0008);
		fan_en <= 1'b0;
		wait_st(S_LOCK, 6);
		fan_en <= 1'b1;
		wb(1'b1, `BSS_A_CTRL, 32'h8000_0008);
		wait_st(S_RUN, 60);
		// Third contact open names the lockout cause
		contacts <= 8'hFB;
		repeat (4) @(posedge clk);
		flame_en <= 1'b0;
		wait_st(S_LOCK, 6);
		chk({31'h0, main_v}, 32'h0);
		wb(1'b0, `BSS_A_MSG, 32'h0);
		chk({4'h0, r[27:0]}, 32'h024F_5045);
		demand <= 1'b0;
		flame_en <= 1'b1;
		contacts <= 8'hFF;
		wb(1'b1, `BSS_A_CTRL, 32'h8000_0008);
		wait_st(S_SBY, 6);
	endtask

	task t_src;
		for (int s = 0; s < 3; s++) begin
			// Last pass uses an intermittent pilot, kept on in run
			wb(1'b1, `BSS_A_CTRL, ((s == 2) ? 32'h0000_0010 :
				32'h0000_0008) | (32'(s) << 5));
			demand <= 1'b1;
			wait_st(S_IGN, 60);
			chk({29'h0, hot_s, ext_ign, spark}, 32'h1 << s);
			chk({30'h0, pilot_v, main_v}, 32'h2);
			wait_st(S_RUN, 30);
			chk({31'h0, pilot_v}, (s == 2) ? 32'h1 : 32'h0);
			demand <= 1'b0;
			wait_st(S_SBY, 6);
		end
	endtask

	task t_hold;
		// Hold is set while still idle
		wb(1'b1, `BSS_A_CTRL, 32'h0000_000C);
		demand <= 1'b1;
		wait_st(S_IGN, 60);
		secs(4);
		wb(1'b0, `BSS_A_STAT, 32'h0);
		chk({r[31:16], 13'h0, r[2:0]}, {16'h1, 13'h0, S_IGN});
		chk({28'h0, r[11:8]}, 32'h0);
		chk({31'h0, hold}, 32'h1);
		flame_en <= 1'b0;
		secs(8);
		flame_en <= 1'b1;
		secs(3);
		flame_en <= 1'b0;
		secs(8);
		chk({31'h0, lockout}, 32'h0);
		secs(3);
		chk({31'h0, lockout}, 32'h1);
		flame_en <= 1'b1;
		demand <= 1'b0;
		wb(1'b1, `BSS_A_CTRL, 32'h8000_0004);
		wait_st(S_SBY, 6);
		demand <= 1'b1;
		wait_st(S_RUN, 60);
		chk({31'h0, hold}, 32'h0);
		chk({30'h0, pilot_v, main_v}, 32'h1);
		demand <= 1'b0;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		wrap_up;
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_i <= 1'b0;
		@(posedge clk);
		t_regs;
		t_ann;
		t_stab;
		t_faults;
		t_src;
		t_hold;
		wrap_up;
	end
endmodule
